// [rtl/sfp_host.sv]
// Host controller that reads and sector-programs a parallel flash
`default_nettype none
// How it works
// - Host loads all 128 bytes per sector
// - Every program opens with three unlock writes
// - Byte load: write strobe pulse, output high
// - Next load within 150 us of previous
// - Upper address bits hold the sector, stable
// - Poll top bit; wait before next access
module sfp_host #(
  parameter int                             PWRUP_CYC    = sfp_pkg::T_PWRUP_CYC,
  parameter int                             LOAD_END_CYC = sfp_pkg::T_LOAD_END_CYC,
  parameter int                             PROG_MAX_CYC = sfp_pkg::T_PROG_MAX_CYC,
  parameter logic [sfp_pkg::ADDR_W-1:0]     UNLK_A0      = sfp_pkg::UNLK_ADDR0,
  parameter logic [sfp_pkg::ADDR_W-1:0]     UNLK_A1      = sfp_pkg::UNLK_ADDR1,
  parameter logic [sfp_pkg::ADDR_W-1:0]     UNLK_A2      = sfp_pkg::UNLK_ADDR2,
  parameter logic [sfp_pkg::DATA_W-1:0]     UNLK_D0      = sfp_pkg::UNLK_DATA0,
  parameter logic [sfp_pkg::DATA_W-1:0]     UNLK_D1      = sfp_pkg::UNLK_DATA1,
  parameter logic [sfp_pkg::DATA_W-1:0]     UNLK_D2      = sfp_pkg::UNLK_DATA2
) (
  input  wire logic                         clk_sys,
  input  wire logic                         srst,
  input  wire logic                         cmd_valid,
  output      logic                         cmd_ready,
  input  wire sfp_pkg::sfp_op_e             cmd_op,
  input  wire logic [sfp_pkg::ADDR_W-1:0]   cmd_addr,
  input  wire logic                         wr_valid,
  output      logic                         wr_ready,
  input  wire logic [sfp_pkg::DATA_W-1:0]   wr_data,
  output var  logic                         rd_valid,
  output var  logic [sfp_pkg::DATA_W-1:0]   rd_data,
  output var  logic                         prog_done,
  output var  logic                         prog_fail,
  output      logic                         busy,
  output      logic [sfp_pkg::ADDR_W-1:0]   address_lines,
  output      logic                         ce_n,
  output      logic                         oe_n,
  output      logic                         we_n,
  output      logic [sfp_pkg::DATA_W-1:0]   data_lines_out,
  output      logic                         data_lines_oe,
  input  wire logic [sfp_pkg::DATA_W-1:0]   data_lines_in
);
  import sfp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [ADDR_W-1:0] flash_addr(input logic [SECT_W-1:0] sect,
                                                   input logic [OFS_W-1:0]  ofs);
    flash_addr = {sect, ofs};
  endfunction

  function automatic logic hit(input logic [CNT_W-1:0] cnt, input int lim);
    hit = (cnt >= CNT_W'(lim - 1));
  endfunction

  sfp_state_e        state_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [1:0]        step_r;
  logic [SECT_W-1:0] sect_r;
  logic [OFS_W-1:0]  ofs_r;
  logic [ADDR_W-1:0] rd_addr_r;
  logic [ADDR_W-1:0] last_addr_r;
  logic [DATA_W-1:0] last_data_r;

  wire logic              cyc_busy;
  wire logic              cyc_done;
  wire logic [DATA_W-1:0] cyc_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle launch selection
  wire logic cyc_free   = !cyc_busy;
  wire logic st_idle    = (state_r == S_IDLE);
  wire logic st_unlock  = (state_r == S_UNLOCK);
  wire logic st_load    = (state_r == S_LOAD);
  wire logic st_read    = (state_r == S_READ);
  wire logic st_poll    = (state_r == S_POLL);
  wire logic take_cmd   = cmd_valid && cmd_ready;
  wire logic take_byte  = wr_valid && wr_ready;
  wire logic poll_ok    = (cyc_rdata[POLL_BIT] == last_data_r[POLL_BIT]);

  assign cmd_ready = st_idle && cyc_free;              // Waits out programming and pin cycle
  assign wr_ready  = st_load && cyc_free;              // Next byte follows at once
  assign busy      = !st_idle;

  wire logic cyc_start = (st_unlock && cyc_free) || take_byte ||
                         ((st_read || st_poll) && cyc_free && !cyc_done);
  wire logic cyc_write = st_unlock || st_load;

  wire logic [ADDR_W-1:0] unlk_addr = (step_r == 2'd0) ? UNLK_A0 :
                                      (step_r == 2'd1) ? UNLK_A1 : UNLK_A2;
  wire logic [DATA_W-1:0] unlk_data = (step_r == 2'd0) ? UNLK_D0 :
                                      (step_r == 2'd1) ? UNLK_D1 : UNLK_D2;
  wire logic [ADDR_W-1:0] cyc_addr  = st_unlock ? unlk_addr :
                                      st_load   ? flash_addr(sect_r, ofs_r) :
                                      st_poll   ? last_addr_r : rd_addr_r;
  wire logic [DATA_W-1:0] cyc_wdata = st_unlock ? unlk_data : wr_data;

  ////////////////////////////////////////////////////////////////////////////
  // Pin cycle engine
  sfp_cycle u_cycle (
    .clk_sys        (clk_sys),
    .srst           (srst),
    .start          (cyc_start),
    .is_write       (cyc_write),
    .addr_in        (cyc_addr),
    .wdata_in       (cyc_wdata),
    .busy           (cyc_busy),
    .done           (cyc_done),
    .rdata          (cyc_rdata),
    .address_lines  (address_lines),
    .ce_n           (ce_n),
    .oe_n           (oe_n),
    .we_n           (we_n),
    .data_lines_out (data_lines_out),
    .data_lines_oe  (data_lines_oe),
    .data_lines_in  (data_lines_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r     <= S_PWRUP;
      cnt_r       <= '0;
      step_r      <= '0;
      sect_r      <= '0;
      ofs_r       <= '0;
      rd_addr_r   <= '0;
      last_addr_r <= '0;
      last_data_r <= '0;
      rd_valid    <= 1'b0;
      rd_data     <= '0;
      prog_done   <= 1'b0;
      prog_fail   <= 1'b0;
    end else begin
      rd_valid  <= 1'b0;
      prog_done <= 1'b0;
      prog_fail <= 1'b0;
      case (state_r)
        S_PWRUP: begin
          cnt_r <= cnt_r + 1'b1;
          if (hit(cnt_r, PWRUP_CYC)) begin        // Device refuses writes early
            state_r <= S_IDLE;
          end
        end
        S_IDLE: begin
          cnt_r <= '0;
          if (take_cmd) begin
            rd_addr_r <= cmd_addr;
            sect_r    <= cmd_addr[ADDR_W-1:OFS_W]; // Whole sector target
            step_r    <= '0;
            ofs_r     <= '0;
            state_r   <= (cmd_op == SFP_OP_PROG) ? S_UNLOCK : S_READ;
          end
        end
        S_READ: begin
          if (cyc_done) begin
            rd_data  <= cyc_rdata;
            rd_valid <= 1'b1;
            state_r  <= S_IDLE;
          end
        end
        S_UNLOCK: begin
          if (cyc_done) begin                     // Three writes first
            step_r <= step_r + 1'b1;
            if (step_r == 2'd2) begin
              state_r <= S_LOAD;
            end
          end
        end
        S_LOAD: begin
          if (take_byte) begin
            last_addr_r <= cyc_addr;
            last_data_r <= wr_data;
          end
          if (cyc_done) begin                     // All 128 bytes in turn
            ofs_r <= ofs_r + 1'b1;
            cnt_r <= '0;
            if (ofs_r == OFS_LAST) begin
              state_r <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          cnt_r <= cnt_r + 1'b1;
          if (hit(cnt_r, LOAD_END_CYC)) begin     // Idle strobes end the load
            cnt_r   <= '0;
            state_r <= S_POLL;
          end
        end
        default: begin
          cnt_r <= cnt_r + 1'b1;
          if (cyc_done && poll_ok) begin          // Bit 7 equal to bit 7 of the last loaded byte means finished
            prog_done <= 1'b1;
            state_r   <= S_IDLE;
          end else if (hit(cnt_r, PROG_MAX_CYC)) begin
            prog_fail <= 1'b1;
            state_r   <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule // sfp_host
`default_nettype wire

// [rtl/sfp_pkg.sv]
// Shared constants and types for the sector flash program host
`default_nettype none
package sfp_pkg;
  // Bus shape
  localparam int ADDR_W   = 17;
  localparam int DATA_W   = 8;
  localparam int OFS_W    = 7;                  // Byte within sector
  localparam int SECT_W   = 10;                 // Sector number
  localparam int SECT_BYTES = 128;
  localparam logic [OFS_W-1:0] OFS_LAST = 7'h7f;
  localparam int POLL_BIT   = 7;                // poll_status_bit position
  localparam int TOGGLE_BIT = 6;                // toggle_status_bit position

  // Clock and pin timing
  localparam int CLK_NS      = 5;
  localparam int T_ACC_NS    = 120;             // Output drive low until data valid
  localparam int T_WP_NS     = 90;              // Write strobe low width
  localparam int T_FILTER_NS = 15;              // Shorter pulses are ignored by the device
  localparam int T_ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRB_W      = 6;
  localparam logic [STRB_W-1:0] ACC_LAST = STRB_W'(T_ACC_CYC - 1);
  localparam logic [STRB_W-1:0] WP_LAST  = STRB_W'(T_WP_CYC - 1);

  // Long waits (least times round up, longest round down)
  localparam int T_LOAD_END_US  = 150;
  localparam int T_LOAD_END_CYC = (T_LOAD_END_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int T_PROG_MAX_MS  = 20;
  localparam int T_PROG_MAX_CYC = T_PROG_MAX_MS * 1000000 / CLK_NS;
  localparam int T_PWRUP_MS     = 10;
  localparam int T_PWRUP_CYC    = (T_PWRUP_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W          = 23;

  // Unlock writes, configurable
  localparam logic [ADDR_W-1:0] UNLK_ADDR0 = 17'h0_5555;
  localparam logic [ADDR_W-1:0] UNLK_ADDR1 = 17'h0_2aaa;
  localparam logic [ADDR_W-1:0] UNLK_ADDR2 = 17'h0_5555;
  localparam logic [DATA_W-1:0] UNLK_DATA0 = 8'h00aa;
  localparam logic [DATA_W-1:0] UNLK_DATA1 = 8'h0055;
  localparam logic [DATA_W-1:0] UNLK_DATA2 = 8'h00a0;

  typedef enum logic [0:0] {
    SFP_OP_READ = 1'b0,
    SFP_OP_PROG = 1'b1
  } sfp_op_e;

  typedef enum logic [2:0] {
    S_PWRUP  = 3'b000,
    S_IDLE   = 3'b001,
    S_READ   = 3'b010,
    S_UNLOCK = 3'b011,
    S_LOAD   = 3'b100,
    S_WAIT   = 3'b101,
    S_POLL   = 3'b110
  } sfp_state_e;

  typedef enum logic [1:0] {
    P_IDLE   = 2'b00,
    P_SETUP  = 2'b01,
    P_STROBE = 2'b10,
    P_HOLD   = 2'b11
  } sfp_phase_e;
endpackage
`default_nettype wire

// [rtl/sfp_cycle.sv]
// One read or write cycle on the flash pins
`default_nettype none
module sfp_cycle (
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  input  wire logic                       start,
  input  wire logic                       is_write,
  input  wire logic [sfp_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [sfp_pkg::DATA_W-1:0] wdata_in,
  output      logic                       busy,
  output      logic                       done,
  output var  logic [sfp_pkg::DATA_W-1:0] rdata,
  output var  logic [sfp_pkg::ADDR_W-1:0] address_lines,
  output var  logic                       ce_n,
  output var  logic                       oe_n,
  output var  logic                       we_n,
  output var  logic [sfp_pkg::DATA_W-1:0] data_lines_out,
  output var  logic                       data_lines_oe,
  input  wire logic [sfp_pkg::DATA_W-1:0] data_lines_in
);
  import sfp_pkg::*;

  sfp_phase_e        phase_r;
  logic [STRB_W-1:0] cnt_r;
  logic              wr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Phase decode
  wire logic              strb_end = (cnt_r == (wr_r ? WP_LAST : ACC_LAST));
  assign busy = (phase_r != P_IDLE);
  assign done = (phase_r == P_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // Chip select wraps the strobe: address set before fall, data held past rise
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_r        <= P_IDLE;
      cnt_r          <= '0;
      wr_r           <= 1'b0;
      rdata          <= '0;
      address_lines  <= '0;
      ce_n           <= 1'b1;
      oe_n           <= 1'b1;
      we_n           <= 1'b1;
      data_lines_out <= '0;
      data_lines_oe  <= 1'b0;
    end else begin
      case (phase_r)
        P_IDLE: begin
          if (start) begin
            wr_r           <= is_write;
            address_lines  <= addr_in;
            data_lines_out <= wdata_in;
            data_lines_oe  <= is_write;  // Data driven only for writes (unlock and load)
            ce_n           <= 1'b0;
            phase_r        <= P_SETUP;
          end
        end
        P_SETUP: begin
          cnt_r   <= '0;
          phase_r <= P_STROBE;
          if (wr_r) begin
            we_n <= 1'b0;       // Later falling edge latches address
          end else begin
            oe_n <= 1'b0;       // Output drive only on reads
          end
        end
        P_STROBE: begin
          cnt_r <= cnt_r + 1'b1;
          if (strb_end) begin
            we_n    <= 1'b1;    // First rising edge latches data
            oe_n    <= 1'b1;
            phase_r <= P_HOLD;
            if (!wr_r) begin
              rdata <= data_lines_in;
            end
          end
        end
        default: begin
          ce_n          <= 1'b1;
          data_lines_oe <= 1'b0;
          phase_r       <= P_IDLE;
        end
      endcase
    end
  end
endmodule // sfp_cycle
`default_nettype wire

// [test/sfp_flash_model.sv]
// Behavioural sector flash device that answers the host pins
`default_nettype none
module sfp_flash_model #(
  parameter int PWR      = 20,
  parameter int LOAD_END = 30,
  parameter int PROG_CYC = 300
) (
  input  wire logic                       clk_sys,
  input  wire logic                       hang,
  input  wire logic [sfp_pkg::ADDR_W-1:0] address_lines,
  input  wire logic                       ce_n,
  input  wire logic                       oe_n,
  input  wire logic                       we_n,
  input  wire logic [sfp_pkg::DATA_W-1:0] dq_in,
  output var  logic [sfp_pkg::DATA_W-1:0] dq_out,
  output      logic                       dq_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  import sfp_pkg::*;
  localparam logic [16:0] UA [3] = '{UNLK_ADDR0, UNLK_ADDR1, UNLK_ADDR2};
  localparam logic [7:0]  UD [3] = '{UNLK_DATA0, UNLK_DATA1, UNLK_DATA2};
  logic [7:0]   mem [0:131071];               // 1024 sectors of 128 bytes
  logic [7:0]   buf_q [0:127];
  logic [127:0] ld;
  logic [16:0]  la;
  logic [9:0]   sect;
  int           pwr = 0, idle = 0, busy = 0, low = 0, step = 0;
  logic         loading = 0, keep = 0, tog = 0, ld7 = 0, stb_q = 0, rd_q = 0;
  wire logic    stb = !ce_n && !we_n && oe_n; // Write only with output high
  wire logic    rd  = !ce_n && !oe_n && we_n;
  initial foreach (mem[i]) mem[i] = 8'hff;
  ////////////////////////////////////////
  // Output drive only while read-selected; status while busy
  assign dq_oe  = rd;
  assign dq_out = busy > 0 ? {~ld7, tog, 6'h00} : mem[address_lines];
  // Strobe tracking, unlock, load window and program timer
  always @(posedge clk_sys) begin
    stb_q <= stb;
    rd_q <= rd;
    if (pwr < PWR) pwr <= pwr + 1;
    low <= stb ? low + 1 : 0;
    if (loading && !stb) idle <= idle + 1;
    if (stb && !stb_q) idle <= 0;
    if (stb && !stb_q) la <= address_lines;   // Later falling edge
    if (rd && !rd_q && busy > 0) tog <= ~tog;
    if (loading && idle >= LOAD_END) begin
      loading <= 0;
      keep <= 1;
      busy <= PROG_CYC;
      step <= 0;
    end
    if (busy > 0 && !hang) busy <= busy - 1;
    if (busy == 1 && !hang && keep) begin     // Erase then program
      for (int i = 0; i < 128; i++) mem[{sect, i[6:0]}] <= ld[i] ? buf_q[i] : 8'hff;
    end
    // Noise filter and power-on lockout
    if (!stb && stb_q && low >= 3 && pwr >= PWR && busy == 0) begin
      if (loading) begin                      // First rising edge, any order
        buf_q[la[6:0]] <= dq_in;
        ld[la[6:0]] <= 1'b1;
        sect <= la[16:7];
        ld7 <= dq_in[7];
      end else if (la == UA[step] && dq_in == UD[step]) begin
        step <= step + 1;
        if (step == 2) loading <= 1;
        if (step == 2) ld <= '0;
        if (step == 2) idle <= 0;             // Fresh load window per program
      end else begin                          // Bare write stores nothing
        step <= 0;
        keep <= 0;
        busy <= PROG_CYC;
      end
    end
  end
endmodule // sfp_flash_model
`default_nettype wire

// [test/sfp_host_chk.sv]
// Pin and handshake assertions for the sector flash host
`default_nettype none
module sfp_host_chk #(
  parameter int                         PWRUP_CYC = 50,
  parameter logic [sfp_pkg::ADDR_W-1:0] UNLK_A0   = sfp_pkg::UNLK_ADDR0,
  parameter logic [sfp_pkg::DATA_W-1:0] UNLK_D0   = sfp_pkg::UNLK_DATA0
) (
  input wire logic                       clk_sys,
  input wire logic                       srst,
  input wire logic                       cmd_valid,
  input wire logic                       cmd_ready,
  input wire sfp_pkg::sfp_op_e           cmd_op,
  input wire logic                       rd_valid,
  input wire logic                       prog_done,
  input wire logic                       prog_fail,
  input wire logic                       busy,
  input wire logic [sfp_pkg::ADDR_W-1:0] address_lines,
  input wire logic                       ce_n,
  input wire logic                       oe_n,
  input wire logic                       we_n,
  input wire logic [sfp_pkg::DATA_W-1:0] data_lines_out,
  input wire logic                       data_lines_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  import sfp_pkg::*;
  int wlow, up;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Strobe low width and time since reset
  always_ff @(posedge clk_sys) begin
    wlow <= we_n ? 0 : wlow + 1;
    up <= srst ? 0 : (up < PWRUP_CYC ? up + 1 : up);
  end
  ////////////////////////////////////////
  no_fight_a: assert property (!(data_lines_oe && !oe_n))
    else $error("host drives data while output enabled");
  rw_excl_a: assert property (!(!oe_n && !we_n))
    else $error("output and write strobe low together");
  wr_sel_a: assert property (!we_n |-> !ce_n && oe_n && data_lines_oe)
    else $error("write strobe without select or data");
  wp_width_a: assert property ($rose(we_n) |-> wlow >= T_WP_CYC)
    else $error("write strobe too short");
  load_hold_a: assert property (!we_n && $past(!we_n) |-> $stable(address_lines) && $stable(data_lines_out))
    else $error("address or data moved under strobe");
  rd_lat_a: assert property (cmd_valid && cmd_ready && cmd_op == SFP_OP_READ |-> ##[27:28] rd_valid)
    else $error("read answer late");
  unlock_a: assert property (cmd_valid && cmd_ready && cmd_op == SFP_OP_PROG
    |-> ##[2:6] (!we_n && address_lines == UNLK_A0 && data_lines_out == UNLK_D0))
    else $error("program does not open with unlock write");
  one_pulse_a: assert property (rd_valid || prog_done || prog_fail |=> !rd_valid && !prog_done && !prog_fail)
    else $error("answer pulse longer than one cycle");
  ready_gate_a: assert property (cmd_ready |-> !busy && up >= PWRUP_CYC - 1)
    else $error("ready while busy or in power-up wait");
endmodule // sfp_host_chk
bind sfp_host sfp_host_chk #(.PWRUP_CYC(PWRUP_CYC), .UNLK_A0(UNLK_A0), .UNLK_D0(UNLK_D0)) chk (
  .clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
  .rd_valid(rd_valid), .prog_done(prog_done), .prog_fail(prog_fail), .busy(busy),
  .address_lines(address_lines), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
  .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));
`default_nettype wire

// [test/tb_sfp_host.sv]
// Self-checking bench for the sector flash host
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_sfp_host;
  timeunit 1ns;
  timeprecision 100ps;
  import sfp_pkg::*;
  logic              clk_sys = 0, srst = 1, cmd_valid = 0, wr_valid = 0, hang = 0;
  sfp_op_e           cmd_op = SFP_OP_READ;
  logic [ADDR_W-1:0] cmd_addr = '0, address_lines;
  logic [DATA_W-1:0] wr_data = '0, rd_data, data_lines_out, dq_out, lastv = '0;
  logic              cmd_ready, wr_ready, rd_valid, prog_done, prog_fail, busy, ce_n, oe_n, we_n, data_lines_oe, dq_oe;
  int                checks = 0, miscompares = 0, seed = 32'h01c1_9418, ref_mem [int];
  logic [7:0]        sect_d [0:127];
  // Undriven bus shows the inverse of its last level
  wire logic [DATA_W-1:0] data_lines_in = dq_oe ? dq_out : data_lines_oe ? data_lines_out : ~lastv;
  always @(posedge clk_sys) lastv <= data_lines_in;
  always #2.5 clk_sys = ~clk_sys;
  sfp_host #(.PWRUP_CYC(50), .LOAD_END_CYC(40), .PROG_MAX_CYC(2000)) dut (.clk_sys(clk_sys), .srst(srst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .prog_done(prog_done),
    .prog_fail(prog_fail), .busy(busy), .address_lines(address_lines), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .data_lines_in(data_lines_in));
  sfp_flash_model dev (.clk_sys(clk_sys), .hang(hang),
    .address_lines(address_lines), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_in(data_lines_out),
    .dq_out(dq_out), .dq_oe(dq_oe));
  ////////////////////////////////////////
  // Verdict and end of run
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Present one command until it is taken
  task automatic take(input sfp_op_e op, input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    @(negedge clk_sys);
    cmd_valid = 1;
    cmd_op = op;
    cmd_addr = a;
    while (cmd_ready !== 1'b1 && n < 200) begin @(negedge clk_sys); n++; end
    `CHK("cmd_ready", 1'b1, cmd_ready)
    @(negedge clk_sys);
    cmd_valid = 0;
  endtask
  // Read one byte and compare with the reference array
  task automatic rd(input int a);
    int n;
    take(SFP_OP_READ, a[ADDR_W-1:0]);
    n = 0;
    while (rd_valid !== 1'b1 && n < 60) begin @(negedge clk_sys); n++; end
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", ref_mem.exists(a) ? ref_mem[a][7:0] : 8'hff, rd_data)
  endtask
  // Program a whole sector of random bytes
  task automatic prog(input int s, input logic fail);
    int n;
    for (int i = 0; i < 128; i++) sect_d[i] = 8'($random(seed));
    take(SFP_OP_PROG, ADDR_W'(s << 7));
    for (int i = 0; i < 128; i++) begin
      wr_valid = 1;
      wr_data = sect_d[i];
      n = 0;
      while (wr_ready !== 1'b1 && n < 200) begin @(negedge clk_sys); n++; end
      @(negedge clk_sys);
    end
    wr_valid = 0;
    n = 0;
    while (prog_done !== 1'b1 && prog_fail !== 1'b1 && n < 4000) begin @(negedge clk_sys); n++; end
    `CHK("prog_fail", fail, prog_fail)
    `CHK("prog_done", !fail, prog_done)
    for (int i = 0; i < 128; i++) ref_mem[s * 128 + i] = sect_d[i];
  endtask
  // Main sequence
  initial begin
    repeat (5) @(negedge clk_sys);
    srst = 0;
    `CHK("cmd_ready", 1'b0, cmd_ready)
    rd(17'h0_0100);
    prog(37, 0);
    rd(37 * 128 + 127);
    rd(37 * 128);
    for (int k = 0; k < 6; k++) rd(37 * 128 + ($random(seed) & 127));
    hang = 1;
    prog(1023, 1);
    hang = 0;
    repeat (400) @(negedge clk_sys);
    rd(1023 * 128 + 5);
    take(SFP_OP_READ, 17'h0_0010);
    repeat (5) @(negedge clk_sys);
    srst = 1;
    @(negedge clk_sys);
    `CHK("ce_n", 1'b1, ce_n)
    srst = 0;
    `CHK("busy", 1'b1, busy)
    rd(1023 * 128 + 127);
    give_verdict();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule // tb_sfp_host
`default_nettype wire
